// ### logic/scc_config.v
// Configuration registers and channel sequencer of the temperature monitor.
`timescale 1ns/100ps
`include "scc_map.vh"
module scc_config #(
    parameter        TWO_REMOTE = 1,
    parameter [35:0] FRAME_CYC  = `SCC_FRAME_CYC,
    parameter [31:0] CONV_CYC   = `SCC_CONV_CYC
) (
    input  wire       CORE_CLK,
    input  wire       NRST,
    input  wire       WR_STB,
    input  wire       RD_STB,
    input  wire [7:0] PTR,
    input  wire [7:0] WDATA,
    input  wire       ALERT_EVENT,
    input  wire       LOCAL_HIGH_FLAG,
    input  wire       REMOTE_HIGH_FLAG,
    output reg  [7:0] RDATA,
    output reg        RD_HIT,
    output reg        CONV_BUSY,
    output reg  [1:0] CONV_CHANNEL,
    output reg        CONV_DONE,
    output reg        RANGE_EXTENDED,
    output reg        SERIES_RESISTANCE_CANCEL,
    output reg        ALERT_PENDING,
    output reg        LIMIT_PIN_N
);
    localparam [7:0] CHEN_PTR   = TWO_REMOTE ? `SCC_PTR_CHEN_2R : `SCC_PTR_CHEN_1R;
    localparam [7:0] CHEN_RST   = TWO_REMOTE ? `SCC_CHEN_RST_2R : `SCC_CHEN_RST_1R;
    localparam [7:0] CHEN_WMASK = TWO_REMOTE ? `SCC_CHEN_WMASK_2R : `SCC_CHEN_WMASK_1R;

    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_LOCAL  = 3'd1;
    localparam [2:0] ST_REM1   = 3'd2;
    localparam [2:0] ST_REM2   = 3'd3;
    localparam [2:0] ST_WAIT   = 3'd4;
    localparam [2:0] ST_HALTED = 3'd5;

    reg        rst_meta;
    reg        rst_n;
    reg  [7:0] measurement_control;
    reg  [7:0] sample_rate_select;
    reg  [7:0] channel_enable_control;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg        one_shot;
    reg        conv_start;
    reg        frame_restart;
    reg  [7:0] next_rdata;
    reg        next_hit;
    wire       standby_halt;
    wire       pin_function_select;
    wire       local_channel_on;
    wire       remote1_channel_on;
    wire       remote2_channel_on;
    wire       series_resistance_cancel;
    wire       conv_done;
    wire       frame_expired;
    wire       wr_oneshot;

    // Reset is released through two stages so every register leaves reset on the same edge.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign standby_halt             = measurement_control[`SCC_BIT_HALT];
    assign pin_function_select      = measurement_control[`SCC_BIT_PINFUNC];
    assign series_resistance_cancel = channel_enable_control[`SCC_BIT_RCANCEL];
    assign local_channel_on         = channel_enable_control[`SCC_BIT_LOCAL];
    assign remote1_channel_on       = channel_enable_control[`SCC_BIT_REMOTE1];
    assign remote2_channel_on       = channel_enable_control[`SCC_BIT_REMOTE2];
    assign wr_oneshot               = WR_STB && (PTR == `SCC_PTR_ONESHOT);

    // Reserved bits of the control and channel enable registers are masked on write; the rate register takes all eight bits.
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            measurement_control    <= `SCC_CTRL_RST;
            sample_rate_select     <= `SCC_RATE_RST;
            channel_enable_control <= CHEN_RST;
        end else if (WR_STB) begin
            if (PTR == `SCC_PTR_CTRL_WR) begin
                measurement_control <= WDATA & `SCC_CTRL_WMASK;
            end
            if (PTR == `SCC_PTR_RATE_WR) begin
                sample_rate_select <= WDATA;
            end
            if (PTR == CHEN_PTR) begin
                channel_enable_control <= WDATA & CHEN_WMASK;
            end
        end
    end

    always @* begin
        next_hit   = 1'b1;
        next_rdata = 8'h00;
        case (PTR)
            `SCC_PTR_CTRL_RD: next_rdata = measurement_control;
            `SCC_PTR_RATE_RD: next_rdata = sample_rate_select;
            CHEN_PTR:         next_rdata = channel_enable_control;
            default:          next_hit   = 1'b0;
        endcase
    end

    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA  <= 8'h00;
            RD_HIT <= 1'b0;
        end else begin
            RD_HIT <= RD_STB && next_hit;
            if (RD_STB) begin
                RDATA <= next_rdata;
            end
        end
    end

    // Next enabled step after the given one; a disabled channel is passed over.
    function [2:0] scc_next_step;
        input [2:0] from;
        input       l_on;
        input       r1_on;
        input       r2_on;
        begin
            scc_next_step = ST_WAIT;
            if (from == ST_IDLE && l_on) begin
                scc_next_step = ST_LOCAL;
            end else if ((from == ST_IDLE || from == ST_LOCAL) && r1_on) begin
                scc_next_step = ST_REM1;
            end else if (from != ST_REM2 && r2_on) begin
                scc_next_step = ST_REM2;
            end
        end
    endfunction

    always @* begin
        next_state    = state;
        conv_start    = 1'b0;
        frame_restart = 1'b0;
        case (state)
            ST_HALTED: begin
                if (!standby_halt || one_shot) begin
                    next_state    = scc_next_step(ST_IDLE, local_channel_on,
                                                  remote1_channel_on, remote2_channel_on);
                    frame_restart = 1'b1;
                    conv_start    = (next_state != ST_WAIT);
                end
            end
            ST_LOCAL, ST_REM1, ST_REM2: begin
                if (conv_done) begin
                    next_state = scc_next_step(state, local_channel_on,
                                               remote1_channel_on, remote2_channel_on);
                    // A period already spent restarts at once instead of idling a cycle.
                    if (next_state == ST_WAIT && frame_expired && !standby_halt) begin
                        next_state    = scc_next_step(ST_IDLE, local_channel_on,
                                                      remote1_channel_on, remote2_channel_on);
                        frame_restart = 1'b1;
                    end
                    conv_start = (next_state != ST_WAIT);
                end
            end
            ST_WAIT: begin
                if (standby_halt) begin
                    next_state = ST_HALTED;
                end else if (frame_expired) begin
                    next_state    = scc_next_step(ST_IDLE, local_channel_on,
                                                  remote1_channel_on, remote2_channel_on);
                    frame_restart = 1'b1;
                    conv_start    = (next_state != ST_WAIT);
                end
            end
            default: begin
                next_state = ST_HALTED;
            end
        endcase
        if (standby_halt && state != ST_HALTED && state != ST_WAIT && !one_shot) begin
            next_state = ST_HALTED;
            conv_start = 1'b0;
        end
    end

    // A one-shot request is held until its sequence ends, so the halt override spares it.
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_HALTED;
            one_shot <= 1'b0;
        end else begin
            state <= next_state;
            if (wr_oneshot && standby_halt) begin
                one_shot <= 1'b1;
            end else if (next_state == ST_WAIT) begin
                one_shot <= 1'b0;
            end
        end
    end

    scc_rate_timer #(
        .FRAME_CYC (FRAME_CYC)
    ) u_rate (
        .clk       (CORE_CLK),
        .rst_n     (rst_n),
        .rate_code (sample_rate_select),
        .restart   (frame_restart),
        .expired   (frame_expired)
    );

    scc_conv_timer #(
        .CONV_CYC (CONV_CYC)
    ) u_conv (
        .clk     (CORE_CLK),
        .rst_n   (rst_n),
        .start   (conv_start),
        .remote  (next_state == ST_REM1 || next_state == ST_REM2),
        .rcancel (series_resistance_cancel),
        .abort   (next_state == ST_HALTED),
        .done    (conv_done)
    );

    // The pin is driven from a flop so a glitch on the flag inputs never reaches it.
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            CONV_BUSY                <= 1'b0;
            CONV_CHANNEL             <= 2'h0;
            CONV_DONE                <= 1'b0;
            RANGE_EXTENDED           <= 1'b0;
            SERIES_RESISTANCE_CANCEL <= 1'b1;
            ALERT_PENDING            <= 1'b0;
            LIMIT_PIN_N              <= 1'b1;
        end else begin
            CONV_BUSY                <= (next_state == ST_LOCAL) || (next_state == ST_REM1)
                                        || (next_state == ST_REM2);
            CONV_CHANNEL             <= next_state[2] ? 2'h0 : next_state[1:0];
            CONV_DONE                <= conv_done;
            RANGE_EXTENDED           <= measurement_control[`SCC_BIT_RANGE];
            SERIES_RESISTANCE_CANCEL <= series_resistance_cancel;
            ALERT_PENDING            <= ALERT_EVENT;
            if (pin_function_select) begin
                LIMIT_PIN_N <= !(LOCAL_HIGH_FLAG || REMOTE_HIGH_FLAG);
            end else begin
                LIMIT_PIN_N <= !(ALERT_EVENT
                                 && !measurement_control[`SCC_BIT_SUPPRESS]);
            end
        end
    end
endmodule // scc_config

// ### logic/scc_conv_timer.v
// Conversion duration timer; remote conversions halve when resistance cancel is off.
`timescale 1ns/100ps
module scc_conv_timer #(
    parameter [31:0] CONV_CYC = 32'd4650000
) (
    input  wire clk,
    input  wire rst_n,
    input  wire start,
    input  wire remote,
    input  wire rcancel,
    input  wire abort,
    output reg  done
);
    reg  [31:0] count;
    reg         running;
    wire [31:0] target;

    assign target = (remote && !rcancel) ? (CONV_CYC >> 1) : CONV_CYC;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 32'h0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
                count   <= 32'h0;
            end else if (start) begin
                running <= 1'b1;
                count   <= 32'h1;
            end else if (running) begin
                // Done is flagged on the last count so the next step starts without a gap.
                if (count + 32'h1 >= target) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count + 32'h1;
                end
            end
        end
    end
endmodule // scc_conv_timer

// ### logic/scc_map.vh
// Register pointers, field positions, reset values and timing counts of the conversion config.
`ifndef SCC_MAP_VH
`define SCC_MAP_VH
`define SCC_PTR_CTRL_RD      8'h03
`define SCC_PTR_CTRL_WR      8'h09
`define SCC_PTR_RATE_RD      8'h04
`define SCC_PTR_RATE_WR      8'h0A
`define SCC_PTR_CHEN_1R      8'h1A
`define SCC_PTR_CHEN_2R      8'h3F
`define SCC_PTR_ONESHOT      8'h0F
`define SCC_CTRL_RST         8'h00
`define SCC_CTRL_WMASK       8'hE4
`define SCC_RATE_RST         8'h07
`define SCC_CHEN_RST_1R      8'h1C
`define SCC_CHEN_RST_2R      8'h3C
`define SCC_CHEN_WMASK_1R    8'h1C
`define SCC_CHEN_WMASK_2R    8'h3C
`define SCC_BIT_SUPPRESS     7
`define SCC_BIT_HALT         6
`define SCC_BIT_PINFUNC      5
`define SCC_BIT_RANGE        2
`define SCC_BIT_RCANCEL      2
`define SCC_BIT_LOCAL        3
`define SCC_BIT_REMOTE1      4
`define SCC_BIT_REMOTE2      5
`define SCC_CLK_HZ           50000000
`define SCC_CONV_MS          93
`define SCC_CONV_CYC         ((`SCC_CONV_MS * (`SCC_CLK_HZ / 1000)))
`define SCC_FRAME_S16        16
`define SCC_FRAME_CYC        (`SCC_FRAME_S16 * `SCC_CLK_HZ)
`endif

// ### logic/scc_rate_timer.v
// Cycle period timer that paces measurement cycles from the rate code.
`timescale 1ns/100ps
module scc_rate_timer #(
    parameter [35:0] FRAME_CYC = 36'd800000000
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] rate_code,
    input  wire       restart,
    output reg        expired
);
    reg  [35:0] count;
    reg  [35:0] period;

    // Codes above 06h give no idle beyond the sequence itself.
    // Expiry is raised a cycle early because the sequencer restarts one edge later.
    always @* begin
        if (rate_code > 8'h06) begin
            period = 36'h0;
        end else begin
            period = FRAME_CYC >> rate_code[2:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 36'h0;
            expired <= 1'b0;
        end else if (restart) begin
            count   <= 36'h0;
            expired <= 1'b0;
        end else if (count + 36'h2 >= period) begin
            expired <= 1'b1;
        end else begin
            count <= count + 36'h1;
        end
    end
endmodule // scc_rate_timer

// ### tb/scc_config_monitor.sv
// Concurrent checks on the ports of the conversion config block.
`timescale 1ns/100ps
module scc_config_monitor #(
    parameter TWO_REMOTE = 1
) (
    input wire       CORE_CLK,
    input wire       NRST,
    input wire       WR_STB,
    input wire       RD_STB,
    input wire [7:0] PTR,
    input wire [7:0] WDATA,
    input wire       ALERT_EVENT,
    input wire       LOCAL_HIGH_FLAG,
    input wire       REMOTE_HIGH_FLAG,
    input wire [7:0] RDATA,
    input wire       RD_HIT,
    input wire       CONV_BUSY,
    input wire       RANGE_EXTENDED,
    input wire       SERIES_RESISTANCE_CANCEL,
    input wire       LIMIT_PIN_N
);
    localparam [7:0] CHEN_PTR = TWO_REMOTE ? 8'h3F : 8'h1A;
    reg [7:0] ctrl;
    // Mirror of the control register, so pin checks follow the written mode.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST)
            ctrl <= 8'h00;
        else if (WR_STB && PTR == 8'h09)
            ctrl <= WDATA & 8'hE4;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    AST_CTRL_RD: assert property (
        RD_STB && PTR == 8'h03 |=> RD_HIT && RDATA == ctrl)
        else $error("control readback wrong");
    AST_CTRL_WR_PTR: assert property (
        RD_STB && PTR == 8'h09 |=> !RD_HIT && RDATA == 8'h00)
        else $error("write pointer answered a read");
    AST_CHEN_RSVD: assert property (
        RD_STB && PTR == CHEN_PTR |=> RD_HIT && RDATA[7:6] == 2'h0 && RDATA[1:0] == 2'h0)
        else $error("channel enable reserved bits set");
    AST_RANGE: assert property (
        WR_STB && PTR == 8'h09 |-> ##2 RANGE_EXTENDED == $past(WDATA[2], 2))
        else $error("range output wrong");
    AST_RCANCEL: assert property (
        WR_STB && PTR == CHEN_PTR |-> ##2 SERIES_RESISTANCE_CANCEL == $past(WDATA[2], 2))
        else $error("cancel output wrong");
    AST_HALT: assert property (
        WR_STB && PTR == 8'h09 && WDATA[6] |-> ##[1:3] !CONV_BUSY)
        else $error("halt did not stop conversion");
    AST_ALERT_PIN: assert property (
        !ctrl[7] && !ctrl[5] && ALERT_EVENT |=> !LIMIT_PIN_N)
        else $error("alert pin not driven");
    AST_SUPPRESS: assert property (
        ctrl[7] && !ctrl[5] |=> LIMIT_PIN_N)
        else $error("suppressed pin went low");
    AST_THERM_PIN: assert property (
        ctrl[5] |=> LIMIT_PIN_N == !($past(LOCAL_HIGH_FLAG) || $past(REMOTE_HIGH_FLAG)))
        else $error("comparator pin wrong");
endmodule // scc_config_monitor
bind scc_config scc_config_monitor #(.TWO_REMOTE(TWO_REMOTE)) mon (
    .CORE_CLK(CORE_CLK),
    .NRST(NRST),
    .WR_STB(WR_STB),
    .RD_STB(RD_STB),
    .PTR(PTR),
    .WDATA(WDATA),
    .ALERT_EVENT(ALERT_EVENT),
    .LOCAL_HIGH_FLAG(LOCAL_HIGH_FLAG),
    .REMOTE_HIGH_FLAG(REMOTE_HIGH_FLAG),
    .RDATA(RDATA),
    .RD_HIT(RD_HIT),
    .CONV_BUSY(CONV_BUSY),
    .RANGE_EXTENDED(RANGE_EXTENDED),
    .SERIES_RESISTANCE_CANCEL(SERIES_RESISTANCE_CANCEL),
    .LIMIT_PIN_N(LIMIT_PIN_N)
);

// ### tb/scc_host_model.sv
// Bus host model issuing single-byte register reads and writes.
`timescale 1ns/100ps
`include "scc_map.vh"
module scc_host_model (
    input  wire       clk,
    output reg        wr_stb,
    output reg        rd_stb,
    output reg  [7:0] ptr,
    output reg  [7:0] wdata,
    input  wire [7:0] rdata,
    input  wire       rd_hit
);
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        ptr = 8'h00;
        wdata = 8'h00;
    end
    task write_reg(input [7:0] p, input [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        ptr <= p;
        wdata <= (p == `SCC_PTR_CTRL_WR) ? (d & `SCC_CTRL_WMASK) : d;
        @(posedge clk);
        wr_stb <= 1'b0;
        ptr <= ~p;
        wdata <= ~d;
    endtask
    task read_reg(input [7:0] p, output [7:0] d, output h);
        @(posedge clk);
        rd_stb <= 1'b1;
        ptr <= p;
        @(posedge clk);
        rd_stb <= 1'b0;
        ptr <= ~p;
        #1;
        d = rdata;
        h = rd_hit;
    endtask
endmodule // scc_host_model

// ### tb/sensor_conversion_config_tb.sv
// Self-checking bench for the conversion config block.
`timescale 1ns/100ps
module sensor_conversion_config_tb;
    localparam FRAME = 6400;
    localparam CONV = 20;
    reg        clk = 1'b0;
    reg        nrst = 1'b0;
    reg        alert = 1'b0;
    reg        local_high_flag = 1'b0;
    reg        remote_high_flag = 1'b0;
    wire       wr_stb, rd_stb, rd_hit, busy, done, range_ext, rcancel, pending, pin_n;
    wire [7:0] ptr, wdata, rdata;
    wire [1:0] chan;
    int        num_errors = 0;
    int        num_checks = 0;
    int        cyc = 0;
    int        n_done = 0;
    int        run, st;
    logic [1:0] cur = 2'h0;
    logic [1:0] q_ch[$];
    int        q_len[$];
    int        q_st[$];
    always #10 clk = ~clk;
    scc_host_model host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .ptr(ptr),
        .wdata(wdata), .rdata(rdata), .rd_hit(rd_hit));
    scc_config #(.TWO_REMOTE(1), .FRAME_CYC(36'd6400), .CONV_CYC(32'd20)) dut (
        .CORE_CLK(clk), .NRST(nrst), .WR_STB(wr_stb), .RD_STB(rd_stb), .PTR(ptr),
        .WDATA(wdata), .ALERT_EVENT(alert), .LOCAL_HIGH_FLAG(local_high_flag),
        .REMOTE_HIGH_FLAG(remote_high_flag), .RDATA(rdata), .RD_HIT(rd_hit), .CONV_BUSY(busy),
        .CONV_CHANNEL(chan), .CONV_DONE(done), .RANGE_EXTENDED(range_ext),
        .SERIES_RESISTANCE_CANCEL(rcancel), .ALERT_PENDING(pending), .LIMIT_PIN_N(pin_n));
    // Records each conversion as channel, busy length and start cycle.
    always @(posedge clk) begin
        if (cur != 2'h0 && (!busy || chan != cur)) begin
            q_ch.push_back(cur);
            q_len.push_back(run);
            q_st.push_back(st);
        end
        if (!busy) cur = 2'h0;
        else if (chan != cur) begin
            cur = chan;
            run = 1;
            st = cyc;
        end else run = run + 1;
        if (done) n_done = n_done + 1;
        cyc = cyc + 1;
    end
    task finish_test;
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task rd(input [7:0] p, input [7:0] exp_d, input exp_h);
        logic [7:0] d;
        logic       h;
        host.read_reg(p, d, h);
        check("rdata", d, exp_d);
        check("rd_hit", h, exp_h);
    endtask
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task t_regs;
        rd(8'h03, 8'h00, 1'b1);
        rd(8'h04, 8'h07, 1'b1);
        rd(8'h3F, 8'h3C, 1'b1);
        rd(8'h09, 8'h00, 1'b0);
        rd(8'h0A, 8'h00, 1'b0);
        rd(8'h1A, 8'h00, 1'b0);
        check("rcancel", rcancel, 1'b1);
        host.write_reg(8'h09, 8'hE4);
        rd(8'h03, 8'hE4, 1'b1);
        check("range", range_ext, 1'b1);
        host.write_reg(8'h09, 8'h00);
        host.write_reg(8'h3F, 8'hFF);
        rd(8'h3F, 8'h3C, 1'b1);
        host.write_reg(8'h1A, 8'h00);
        rd(8'h3F, 8'h3C, 1'b1);
        host.write_reg(8'h3F, 8'h38);
        settle();
        check("rcancel", rcancel, 1'b0);
        host.write_reg(8'h0A, 8'h0F);
        rd(8'h04, 8'h0F, 1'b1);
    endtask
    task pin(input a, input l, input r, input exp_pin);
        @(posedge clk);
        alert <= a;
        local_high_flag <= l;
        remote_high_flag <= r;
        settle();
        check("pin", pin_n, exp_pin);
    endtask
    task t_pin;
        host.write_reg(8'h09, 8'h00);
        pin(1'b1, 1'b0, 1'b0, 1'b0);
        host.write_reg(8'h09, 8'h80);
        pin(1'b1, 1'b0, 1'b0, 1'b1);
        check("pending", pending, 1'b1);
        host.write_reg(8'h09, 8'h20);
        pin(1'b1, 1'b0, 1'b0, 1'b1);
        pin(1'b0, 1'b1, 1'b0, 1'b0);
        pin(1'b0, 1'b0, 1'b1, 1'b0);
        pin(1'b0, 1'b0, 1'b0, 1'b1);
        check("pending", pending, 1'b0);
    endtask
    task run_case(input [7:0] chen, input [7:0] rate);
        logic [1:0] ech[3];
        int         elen[3], eoff[3];
        int         n, tot, per, i, w;
        host.write_reg(8'h09, 8'h40);
        host.write_reg(8'h3F, chen);
        host.write_reg(8'h0A, rate);
        n = 0;
        tot = 0;
        for (i = 0; i < 3; i++) if (chen[3+i]) begin
            ech[n] = i + 1;
            elen[n] = (i > 0 && !chen[2]) ? CONV / 2 : CONV;
            eoff[n] = tot;
            tot += elen[n];
            n++;
        end
        per = (rate <= 8'h06) ? (FRAME >> rate) : tot;
        settle();
        q_ch.delete();
        q_len.delete();
        q_st.delete();
        host.write_reg(8'h09, 8'h00);
        for (w = 0; q_ch.size() < 2 * n && w < 20000; w++) @(posedge clk);
        host.write_reg(8'h09, 8'h40);
        check("frames", q_ch.size() >= 2 * n, 1'b1);
        for (i = 0; i < 2 * n && i < q_ch.size(); i++) begin
            check("channel", q_ch[i], ech[i % n]);
            check("length", q_len[i], elen[i % n]);
            check("start", q_st[i] - q_st[0], (i / n) * per + eoff[i % n]);
        end
        settle();
        q_ch.delete();
        q_len.delete();
        q_st.delete();
        n_done = 0;
        host.write_reg(8'h0F, 8'h00);
        repeat (300) @(posedge clk);
        check("one_shot", q_ch.size(), n);
        check("done", n_done, n);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_pin();
        for (int k = 0; k < 8; k++) run_case(8'h3C, k[7:0]);
        run_case(8'h3C, 8'h0F);
        run_case(8'h30, 8'h06);
        run_case(8'h1C, 8'h07);
        run_case(8'h24, 8'h05);
        run_case(8'h08, 8'h06);
        finish_test();
    end
    // Generous bound: the full run needs about 18000 cycles.
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule // sensor_conversion_config_tb
